// *** rtl/lpf_stage_supervisor.sv ***
`timescale 1ns/1ns
module lpf_stage_supervisor
(
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [7:0]                    paddr,
   input  wire logic [31:0]                   pwdata,
   output wire logic [31:0]                   prdata,
   output wire logic                          pready,
   output wire logic                          pslverr,
   input  wire logic                          pf_valid,
   input  wire logic [lpf_pkg::PFW-1:0]       pf_value,
   input  wire logic                          blk_in,
   input  wire logic [lpf_pkg::TSW-1:0]       time_stamp,
   input  wire logic [lpf_pkg::GW-1:0]        setting_group,
   output wire logic                          stage_blocked,
   output wire logic                          stage_start,
   output wire logic                          stage_trip,
   output wire logic                          stage_alarm_start,
   output wire logic                          stage_alarm,
   output lpf_pkg::lpf_cond_e                 stage_condition,
   output wire logic                          pf_event_valid,
   output wire logic [lpf_pkg::IW-1:0]        pf_event_code,
   output wire logic [lpf_pkg::TSW-1:0]       pf_event_stamp
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic pick_fn
   (
      input logic                    held,
      input logic [lpf_pkg::PFW-1:0] pf,
      input logic [lpf_pkg::PFW-1:0] thr
   );
      logic [13:0] a;
      logic [13:0] b;
      a = 14'(pf) * 14'(lpf_pkg::PCT);
      b = 14'(thr) * 14'(lpf_pkg::RLS_PCT);
      if (held)
      begin
         pick_fn = !(a > b);
      end
      else
      begin
         pick_fn = (pf < thr);
      end
   endfunction

   function automatic logic [lpf_pkg::RW-1:0] ratio_fn
   (
      input logic [lpf_pkg::PFW-1:0] pf,
      input logic [lpf_pkg::PFW-1:0] thr
   );
      logic [31:0] q;
      q = (32'(pf) * 32'(lpf_pkg::RATIO_SCALE)) / ((thr == '0) ? 32'h0000_0001 : 32'(thr));
      ratio_fn = q[lpf_pkg::RW-1:0];
   endfunction

   // Wraps to two's complement, which gives the signed trip countdown.
   function automatic logic [lpf_pkg::TW-1:0] remain_fn
   (
      input lpf_pkg::lpf_chan_s     c,
      input logic [lpf_pkg::TW-1:0] d
   );
      remain_fn = (c.act | c.done) ? d - c.cnt : '0;
   endfunction

   function automatic logic [lpf_pkg::TW-1:0] clip_fn
   (
      input logic [lpf_pkg::TW-1:0] v
   );
      clip_fn = v[lpf_pkg::TW-1] ? '0 : v;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   lpf_pkg::lpf_state_s                      st_r;
   lpf_pkg::lpf_state_s                      st_nxt;
   lpf_pkg::lpf_chan_s [lpf_pkg::NCH-1:0]    chn;
   logic [lpf_pkg::NCH-1:0]                  pk;
   logic [lpf_pkg::NCH-1:0]                  en;
   logic [lpf_pkg::NEV-1:0]                  o_new;
   logic [lpf_pkg::NEV-1:0]                  ev_on;
   logic [lpf_pkg::NEV-1:0]                  ev_off;
   logic [lpf_pkg::NEV-1:0]                  clr;
   logic [31:0]                              rdat;
   logic [lpf_pkg::TW-1:0]                   rem_t;
   logic [lpf_pkg::TW-1:0]                   rem_a;
   logic                                     hit;
   logic                                     setup;
   logic                                     wr;
   logic                                     blk;
   logic                                     found;
   logic [lpf_pkg::IW-1:0]                   ecode;

   assign prdata            = st_r.prdata;
   assign pready            = st_r.pready;
   assign pslverr           = st_r.pslverr;
   assign stage_blocked     = st_r.outs[lpf_pkg::EV_BLK];
   assign stage_start       = st_r.outs[lpf_pkg::EV_START];
   assign stage_trip        = st_r.outs[lpf_pkg::EV_TRIP];
   assign stage_alarm_start = st_r.outs[lpf_pkg::EV_ASTART];
   assign stage_alarm       = st_r.outs[lpf_pkg::EV_ALARM];
   assign stage_condition   = st_r.cond;
   assign pf_event_valid    = st_r.evt_valid;
   assign pf_event_code     = st_r.evt_code;
   assign pf_event_stamp    = st_r.evt_stamp;

   always_comb
   begin
      st_nxt = st_r;
      chn    = st_r.ch;
      pk     = '0;
      en     = '0;
      o_new  = st_r.outs;
      ev_on  = '0;
      ev_off = '0;
      clr    = '0;
      rdat   = '0;
      hit    = 1'b1;
      found  = 1'b0;
      ecode  = '0;
      blk    = st_r.blk_s;
      setup  = psel & ~penable;
      wr     = psel & penable & st_r.pready & pwrite;
      rem_t  = remain_fn(st_r.ch[lpf_pkg::CH_TRIP], st_r.dly[lpf_pkg::CH_TRIP]);
      rem_a  = clip_fn(remain_fn(st_r.ch[lpf_pkg::CH_ALARM], st_r.dly[lpf_pkg::CH_ALARM]));

      // ------------------------------------------------------------
      // Blocking input synchroniser
      // ------------------------------------------------------------
      st_nxt.blk_sy = {st_r.blk_sy[1:0], blk_in};
      if (st_r.blk_sy[1] == st_r.blk_sy[2])
      begin
         st_nxt.blk_s = st_r.blk_sy[2];
      end

      // ------------------------------------------------------------
      // APB slave, no wait states, answer registered
      // ------------------------------------------------------------
      case (paddr)
         lpf_pkg::A_CTRL: rdat = 32'(st_r.trips_only);
         lpf_pkg::A_TTHR: rdat = 32'(st_r.thr[lpf_pkg::CH_TRIP]);
         lpf_pkg::A_ATHR: rdat = 32'(st_r.thr[lpf_pkg::CH_ALARM]);
         lpf_pkg::A_TDLY: rdat = 32'(st_r.dly[lpf_pkg::CH_TRIP]);
         lpf_pkg::A_ADLY: rdat = 32'(st_r.dly[lpf_pkg::CH_ALARM]);
         lpf_pkg::A_RDLY: rdat = 32'(st_r.rel_dly);
         lpf_pkg::A_STAT: rdat = 32'({st_r.outs, 1'b0, st_r.cond});
         lpf_pkg::A_EXPA: rdat = 32'(st_r.dly[lpf_pkg::CH_ALARM]);
         lpf_pkg::A_REMA: rdat = 32'(rem_a);
         lpf_pkg::A_EXPT: rdat = 32'(st_r.dly[lpf_pkg::CH_TRIP]);
         lpf_pkg::A_REMT: rdat = {{(32-lpf_pkg::TW){rem_t[lpf_pkg::TW-1]}}, rem_t};
         lpf_pkg::A_RATA: rdat = 32'(st_r.ratio[lpf_pkg::CH_ALARM]);
         lpf_pkg::A_RATT: rdat = 32'(st_r.ratio[lpf_pkg::CH_TRIP]);
         lpf_pkg::A_CBLK: rdat = 32'(st_r.cnt[lpf_pkg::EV_BLK]);
         lpf_pkg::A_CSTA: rdat = 32'(st_r.cnt[lpf_pkg::EV_START]);
         lpf_pkg::A_CTRP: rdat = 32'(st_r.cnt[lpf_pkg::EV_TRIP]);
         lpf_pkg::A_CAST: rdat = 32'(st_r.cnt[lpf_pkg::EV_ASTART]);
         lpf_pkg::A_CALM: rdat = 32'(st_r.cnt[lpf_pkg::EV_ALARM]);
         lpf_pkg::A_FSEL: rdat = 32'({st_r.nrec, st_r.wptr, st_r.sel});
         lpf_pkg::A_FW0:  rdat = 32'(st_r.rec[st_r.sel].stamp);
         lpf_pkg::A_FW1:  rdat = 32'({st_r.rec[st_r.sel].ev, st_r.rec[st_r.sel].grp, 5'h00,
                                      st_r.rec[st_r.sel].rem});
         lpf_pkg::A_FW2:  rdat = 32'({st_r.rec[st_r.sel].pf200, st_r.rec[st_r.sel].pf20,
                                      st_r.rec[st_r.sel].pf});
         lpf_pkg::A_EVEN: rdat = 32'(st_r.evt_en);
         default:         hit  = 1'b0;
      endcase
      st_nxt.pready  = setup;
      st_nxt.pslverr = setup & ~hit;
      if (setup)
      begin
         st_nxt.prdata = hit ? rdat : '0;
      end

      if (wr)
      begin
         case (paddr)
            lpf_pkg::A_CTRL:
            begin
               st_nxt.trips_only = pwdata[lpf_pkg::CT_MODE];
               clr               = pwdata[lpf_pkg::CT_CLR +: lpf_pkg::NEV];
            end
            lpf_pkg::A_TTHR: st_nxt.thr[lpf_pkg::CH_TRIP]  = pwdata[lpf_pkg::PFW-1:0];
            lpf_pkg::A_ATHR: st_nxt.thr[lpf_pkg::CH_ALARM] = pwdata[lpf_pkg::PFW-1:0];
            lpf_pkg::A_TDLY: st_nxt.dly[lpf_pkg::CH_TRIP]  = pwdata[lpf_pkg::TW-1:0];
            lpf_pkg::A_ADLY: st_nxt.dly[lpf_pkg::CH_ALARM] = pwdata[lpf_pkg::TW-1:0];
            lpf_pkg::A_RDLY: st_nxt.rel_dly                = pwdata[lpf_pkg::TW-1:0];
            lpf_pkg::A_FSEL:
            begin
               if (pwdata[lpf_pkg::IW-1:0] < 4'(lpf_pkg::NREC))
               begin
                  st_nxt.sel = pwdata[lpf_pkg::IW-1:0];
               end
            end
            lpf_pkg::A_EVEN: st_nxt.evt_en = pwdata[2*lpf_pkg::NEV-1:0];
            default:
            begin
            end
         endcase
      end

      // A cleared counter that sees an event in the same cycle restarts at one.
      for (int i = 0; i < lpf_pkg::NEV; i++)
      begin
         if (clr[i])
         begin
            st_nxt.cnt[i] = '0;
         end
      end

      // ------------------------------------------------------------
      // Event port, one queued event per clock
      // ------------------------------------------------------------
      st_nxt.evt_valid = 1'b0;
      for (int k = 2*lpf_pkg::NEV-1; k >= 0; k--)
      begin
         if (st_r.evp[k])
         begin
            found = 1'b1;
            ecode = 4'(k);
         end
      end
      if (found)
      begin
         st_nxt.evt_valid     = 1'b1;
         st_nxt.evt_code      = ecode;
         st_nxt.evp[ecode]    = 1'b0;
      end

      // ------------------------------------------------------------
      // Processing cycle, one per power factor sample
      // ------------------------------------------------------------
      if (pf_valid)
      begin
         st_nxt.hist = {st_r.hist[lpf_pkg::PREF_N-2:0], pf_value};
         for (int c = 0; c < lpf_pkg::NCH; c++)
         begin
            en[c]  = (c == lpf_pkg::CH_TRIP) | ~st_r.trips_only;
            pk[c]  = pick_fn(st_r.ch[c].pick, pf_value, st_r.thr[c]) & en[c];
            chn[c].pick = pk[c];
            st_nxt.ratio[c] = en[c] ? ratio_fn(pf_value, st_r.thr[c]) : '0;
            if (!en[c])
            begin
               chn[c] = '0;
            end
            else if (pk[c] & ~blk)
            begin
               chn[c].act = 1'b1;
               chn[c].rel = 1'b0;
               if (!chn[c].done)
               begin
                  if (chn[c].cnt >= st_r.dly[c])
                  begin
                     chn[c].done = 1'b1;
                  end
                  else
                  begin
                     chn[c].cnt = chn[c].cnt + 20'h0_0001;
                  end
               end
               if (chn[c].cnt >= st_r.dly[c])
               begin
                  chn[c].done = 1'b1;
               end
            end
            else if (st_r.ch[c].act | st_r.ch[c].done)
            begin
               chn[c].act  = 1'b0;
               chn[c].done = 1'b0;
               chn[c].rel  = 1'b1;
               chn[c].rcnt = '0;
            end
            else if (st_r.ch[c].rel)
            begin
               if (st_r.ch[c].rcnt + 20'h0_0001 >= st_r.rel_dly)
               begin
                  chn[c].rel = 1'b0;
                  chn[c].cnt = '0;
               end
               else
               begin
                  chn[c].rcnt = st_r.ch[c].rcnt + 20'h0_0001;
               end
            end
         end
         st_nxt.ch = chn;

         o_new[lpf_pkg::EV_BLK]    = blk & (|pk);
         o_new[lpf_pkg::EV_START]  = chn[lpf_pkg::CH_TRIP].act;
         o_new[lpf_pkg::EV_TRIP]   = chn[lpf_pkg::CH_TRIP].done;
         o_new[lpf_pkg::EV_ASTART] = chn[lpf_pkg::CH_ALARM].act;
         o_new[lpf_pkg::EV_ALARM]  = chn[lpf_pkg::CH_ALARM].done;
         st_nxt.outs = o_new;

         if (o_new[lpf_pkg::EV_TRIP])
         begin
            st_nxt.cond = lpf_pkg::LPF_TRIP;
         end
         else if (o_new[lpf_pkg::EV_START])
         begin
            st_nxt.cond = lpf_pkg::LPF_START;
         end
         else if (o_new[lpf_pkg::EV_BLK])
         begin
            st_nxt.cond = lpf_pkg::LPF_BLOCKED;
         end
         else if (o_new[lpf_pkg::EV_ALARM])
         begin
            st_nxt.cond = lpf_pkg::LPF_ALARM;
         end
         else if (o_new[lpf_pkg::EV_ASTART])
         begin
            st_nxt.cond = lpf_pkg::LPF_ASTART;
         end
         else
         begin
            st_nxt.cond = lpf_pkg::LPF_NORMAL;
         end

         ev_on  = o_new & ~st_r.outs;
         ev_off = st_r.outs & ~o_new;
         if ((ev_on | ev_off) != '0)
         begin
            st_nxt.evt_stamp = time_stamp;
         end
         for (int i = 0; i < lpf_pkg::NEV; i++)
         begin
            if (ev_on[i] & st_r.evt_en[2*i])
            begin
               st_nxt.evp[2*i] = 1'b1;
            end
            if (ev_off[i] & st_r.evt_en[2*i+1])
            begin
               st_nxt.evp[2*i+1] = 1'b1;
            end
            if (ev_on[i])
            begin
               st_nxt.cnt[i] = st_nxt.cnt[i] + 16'h0001;
            end
         end

         // A trip and a start in one cycle share one record, named after the trip.
         if (ev_on[lpf_pkg::EV_START] | ev_on[lpf_pkg::EV_TRIP] | ev_on[lpf_pkg::EV_BLK])
         begin
            st_nxt.rec[st_r.wptr].stamp = time_stamp;
            st_nxt.rec[st_r.wptr].ev    = ev_on[lpf_pkg::EV_TRIP]  ? 4'(2*lpf_pkg::EV_TRIP) :
                                          ev_on[lpf_pkg::EV_START] ? 4'(2*lpf_pkg::EV_START) :
                                                                     4'(2*lpf_pkg::EV_BLK);
            st_nxt.rec[st_r.wptr].pf    = pf_value;
            st_nxt.rec[st_r.wptr].pf20  = st_r.hist[lpf_pkg::PRE_N-1];
            st_nxt.rec[st_r.wptr].pf200 = st_r.hist[lpf_pkg::PREF_N-1];
            st_nxt.rec[st_r.wptr].grp   = setting_group;
            st_nxt.rec[st_r.wptr].rem   = clip_fn(remain_fn(chn[lpf_pkg::CH_TRIP],
                                                            st_r.dly[lpf_pkg::CH_TRIP]));
            st_nxt.wptr = (st_r.wptr == 4'(lpf_pkg::NREC-1)) ? '0 : st_r.wptr + 4'h1;
            if (st_r.nrec < 4'(lpf_pkg::NREC))
            begin
               st_nxt.nrec = st_r.nrec + 4'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Register
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r                          <= '0;
         st_r.thr[lpf_pkg::CH_TRIP]    <= lpf_pkg::TRIP_THR_RST;
         st_r.thr[lpf_pkg::CH_ALARM]   <= lpf_pkg::ALARM_THR_RST;
         st_r.dly[lpf_pkg::CH_TRIP]    <= lpf_pkg::TRIP_DLY_RST;
         st_r.dly[lpf_pkg::CH_ALARM]   <= lpf_pkg::ALARM_DLY_RST;
         st_r.rel_dly                  <= lpf_pkg::REL_DLY_RST;
         st_r.evt_en                   <= lpf_pkg::EVT_EN_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

endmodule

// *** rtl/lpf_pkg.sv ***
package lpf_pkg;
   localparam int PFW         = 7;
   localparam int TW          = 20;
   localparam int RW          = 18;
   localparam int CW          = 16;
   localparam int GW          = 3;
   localparam int TSW         = 32;
   localparam int IW          = 4;
   localparam int NCH         = 2;
   localparam int CH_TRIP     = 0;
   localparam int CH_ALARM    = 1;
   localparam int NEV         = 5;
   localparam int EV_BLK      = 0;
   localparam int EV_START    = 1;
   localparam int EV_TRIP     = 2;
   localparam int EV_ASTART   = 3;
   localparam int EV_ALARM    = 4;
   localparam int NREC        = 12;
   localparam int CYC_MS      = 5;
   localparam int PRE_MS      = 20;
   localparam int PREF_MS     = 200;
   localparam int PRE_N       = PRE_MS / CYC_MS;
   localparam int PREF_N      = PREF_MS / CYC_MS;
   localparam int PCT         = 100;
   localparam int RLS_PCT     = 103;
   localparam int RATIO_SCALE = 10000;
   localparam int CT_MODE     = 0;
   localparam int CT_CLR      = 1;

   localparam logic [PFW-1:0] TRIP_THR_RST  = 7'h50;
   localparam logic [PFW-1:0] ALARM_THR_RST = 7'h5A;
   localparam logic [TW-1:0]  TRIP_DLY_RST  = 20'h0_0014;
   localparam logic [TW-1:0]  ALARM_DLY_RST = 20'h0_0014;
   localparam logic [TW-1:0]  REL_DLY_RST   = 20'h0_0004;
   localparam logic [2*NEV-1:0] EVT_EN_RST  = 10'h3FF;

   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_TTHR  = 8'h04;
   localparam logic [7:0] A_ATHR  = 8'h08;
   localparam logic [7:0] A_TDLY  = 8'h0C;
   localparam logic [7:0] A_ADLY  = 8'h10;
   localparam logic [7:0] A_RDLY  = 8'h14;
   localparam logic [7:0] A_STAT  = 8'h18;
   localparam logic [7:0] A_EXPA  = 8'h1C;
   localparam logic [7:0] A_REMA  = 8'h20;
   localparam logic [7:0] A_EXPT  = 8'h24;
   localparam logic [7:0] A_REMT  = 8'h28;
   localparam logic [7:0] A_RATA  = 8'h2C;
   localparam logic [7:0] A_RATT  = 8'h30;
   localparam logic [7:0] A_CBLK  = 8'h34;
   localparam logic [7:0] A_CSTA  = 8'h38;
   localparam logic [7:0] A_CTRP  = 8'h3C;
   localparam logic [7:0] A_CAST  = 8'h40;
   localparam logic [7:0] A_CALM  = 8'h44;
   localparam logic [7:0] A_FSEL  = 8'h48;
   localparam logic [7:0] A_FW0   = 8'h4C;
   localparam logic [7:0] A_FW1   = 8'h50;
   localparam logic [7:0] A_FW2   = 8'h54;
   localparam logic [7:0] A_EVEN  = 8'h58;

   typedef enum logic [2:0] {LPF_NORMAL, LPF_START, LPF_TRIP, LPF_BLOCKED, LPF_ASTART, LPF_ALARM} lpf_cond_e;

   typedef struct packed {
      logic          pick;
      logic          act;
      logic          done;
      logic          rel;
      logic [TW-1:0] cnt;
      logic [TW-1:0] rcnt;
   } lpf_chan_s;

   typedef struct packed {
      logic [TSW-1:0] stamp;
      logic [IW-1:0]  ev;
      logic [GW-1:0]  grp;
      logic [TW-1:0]  rem;
      logic [PFW-1:0] pf200;
      logic [PFW-1:0] pf20;
      logic [PFW-1:0] pf;
   } lpf_rec_s;

   typedef struct packed {
      logic [2:0]                  blk_sy;
      logic                        blk_s;
      lpf_chan_s [NCH-1:0]         ch;
      logic [NCH-1:0][RW-1:0]      ratio;
      logic [NEV-1:0]              outs;
      lpf_cond_e                   cond;
      logic                        trips_only;
      logic [NCH-1:0][PFW-1:0]     thr;
      logic [NCH-1:0][TW-1:0]      dly;
      logic [TW-1:0]               rel_dly;
      logic [2*NEV-1:0]            evt_en;
      logic [2*NEV-1:0]            evp;
      logic [TSW-1:0]              evt_stamp;
      logic                        evt_valid;
      logic [IW-1:0]               evt_code;
      logic [NEV-1:0][CW-1:0]      cnt;
      lpf_rec_s [NREC-1:0]         rec;
      logic [IW-1:0]               wptr;
      logic [IW-1:0]               nrec;
      logic [IW-1:0]               sel;
      logic [PREF_N-1:0][PFW-1:0]  hist;
      logic                        pready;
      logic                        pslverr;
      logic [31:0]                 prdata;
   } lpf_state_s;
endpackage

// *** test/lpf_properties.sv ***
`timescale 1ns/1ns
module lpf_properties
(
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pready,
   input wire logic          pf_valid,
   input wire logic [31:0]   time_stamp,
   input wire logic          stage_blocked,
   input wire logic          stage_start,
   input wire logic          stage_trip,
   input wire logic          stage_alarm_start,
   input wire logic          stage_alarm,
   input lpf_pkg::lpf_cond_e stage_condition,
   input wire logic          pf_event_valid,
   input wire logic [3:0]    pf_event_code,
   input wire logic [31:0]   pf_event_stamp
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [31:0] stamp_r;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         stamp_r <= '0;
      else if (pf_valid)
         stamp_r <= time_stamp;
   sequence start_on_s;
      $rose(stage_start);
   endsequence
   sequence start_ev_s;
      ##[1:12] (pf_event_valid && pf_event_code == 4'h2);
   endsequence
   apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready) else $error("pready not one cycle");
   outs_hold_a: assert property (!pf_valid |=> $stable({stage_blocked, stage_start, stage_trip, stage_alarm_start,
      stage_alarm, stage_condition})) else $error("outputs moved off tick");
   trip_start_a: assert property (stage_trip |-> stage_start) else $error("trip without start");
   alarm_pair_a: assert property (stage_alarm |-> stage_alarm_start) else $error("alarm without start");
   blk_excl_a: assert property (stage_blocked |-> !stage_start && !stage_trip) else $error("blocked timing");
   cond_map_a: assert property (stage_condition == (stage_trip ? lpf_pkg::LPF_TRIP : stage_start ? lpf_pkg::LPF_START
      : stage_blocked ? lpf_pkg::LPF_BLOCKED : stage_alarm ? lpf_pkg::LPF_ALARM : stage_alarm_start ?
      lpf_pkg::LPF_ASTART : lpf_pkg::LPF_NORMAL)) else $error("bad condition");
   start_on_a: assert property (start_on_s |-> start_ev_s) else $error("no start on event");
   start_off_a: assert property ($fell(stage_start) |-> ##[1:12] (pf_event_valid && pf_event_code == 4'h3))
      else $error("no start off event");
   ev_stamp_a: assert property (pf_event_valid |-> pf_event_stamp == stamp_r) else $error("bad stamp");
endmodule
bind lpf_stage_supervisor lpf_properties chk (.*);

// *** test/lpf_meas_src.sv ***
`timescale 1ns/1ns
module lpf_meas_src
#(
   parameter int PER = 24
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [6:0]  pf_req,
   input  wire logic        blk_req,
   output      logic        pf_valid,
   output      logic [6:0]  pf_value,
   output      logic        blk_in,
   output      logic [31:0] time_stamp
);
   logic [7:0] div_r;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         div_r      <= '0;
         pf_valid   <= 1'b0;
         pf_value   <= '0;
         blk_in     <= 1'b0;
         time_stamp <= '0;
      end
      else
      begin
         div_r      <= (div_r == PER - 1) ? 8'h00 : div_r + 8'h01;
         pf_valid   <= (div_r == PER - 1);
         // Value is only meaningful with the strobe, so it toggles elsewhere.
         pf_value   <= (div_r == PER - 1) ? pf_req : ~pf_value;
         time_stamp <= time_stamp + 32'h0000_0001;
         if (pf_valid)
            blk_in <= blk_req;
      end
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ns
module testbench;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, blk_req = 1'b0;
   logic        pready, pslverr, pf_valid, blk_in, e;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, time_stamp, q;
   logic [6:0]  pf_req = 7'h64, pf_value;
   logic [4:0]  outs;
   int          err_total = 0, cmp_count = 0, seed = 32'h9caa, v;
   logic [39:0] rst_tab [6] = '{{lpf_pkg::A_TTHR, 32'h0000_0050}, {lpf_pkg::A_ATHR, 32'h0000_005A},
      {lpf_pkg::A_TDLY, 32'h0000_0014}, {lpf_pkg::A_ADLY, 32'h0000_0014}, {lpf_pkg::A_RDLY, 32'h0000_0004},
      {lpf_pkg::A_EVEN, 32'h0000_03FF}};
   lpf_meas_src src (.pclk(pclk), .presetn(presetn), .pf_req(pf_req), .blk_req(blk_req), .pf_valid(pf_valid),
      .pf_value(pf_value), .blk_in(blk_in), .time_stamp(time_stamp));
   lpf_stage_supervisor uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pf_valid(pf_valid),
      .pf_value(pf_value), .blk_in(blk_in), .time_stamp(time_stamp), .setting_group(3'h5),
      .stage_blocked(outs[0]), .stage_start(outs[1]), .stage_trip(outs[2]), .stage_alarm_start(outs[3]),
      .stage_alarm(outs[4]), .stage_condition(), .pf_event_valid(), .pf_event_code(), .pf_event_stamp());
   initial forever #25 pclk = ~pclk;
   function automatic logic [31:0] ratio(input int pf, input int thr);
      return pf * 10000 / thr;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // -----------------------------------------------------------------
   // Bus cycle and tick helpers.
   // -----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Outputs settle on the edge that samples the strobe; sample on the falling edge after one more clock.
   task automatic tick(input int n);
      repeat (n) @(posedge pclk iff pf_valid);
      @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge pclk);
      err_total++;
      end_of_test();
   end
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rst_tab[i])
      begin
         apb(1'b0, rst_tab[i][39:32], 32'h0000_0000);
         chk(q, rst_tab[i][31:0]);
      end
      apb(1'b1, 8'hFC, 32'h0000_0001);
      chk({31'h0, e}, 32'h0000_0001);
      // The source latches its sample in the same clock that it raises the strobe, so change it before the write.
      pf_req <= 7'h32;
      apb(1'b1, lpf_pkg::A_TDLY, 32'h0000_0003);
      tick(1);
      chk({27'h0, outs}, 32'h0000_000A);
      apb(1'b0, lpf_pkg::A_REMT, 32'h0000_0000);
      chk(q, 32'h0000_0002);
      apb(1'b0, lpf_pkg::A_REMA, 32'h0000_0000);
      chk(q, 32'h0000_0013);
      apb(1'b0, lpf_pkg::A_EXPT, 32'h0000_0000);
      chk(q, 32'h0000_0003);
      apb(1'b0, lpf_pkg::A_RATT, 32'h0000_0000);
      chk(q, ratio(50, 80));
      tick(2);
      chk({27'h0, outs}, 32'h0000_000E);
      apb(1'b0, lpf_pkg::A_STAT, 32'h0000_0000);
      chk(q, 32'h0000_00E2);
      apb(1'b0, lpf_pkg::A_CTRP, 32'h0000_0000);
      chk(q, 32'h0000_0001);
      apb(1'b1, lpf_pkg::A_CTRL, 32'h0000_0008);
      apb(1'b0, lpf_pkg::A_CTRP, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      pf_req <= 7'h52;
      tick(1);
      chk({31'h0, outs[1]}, 32'h0000_0001);
      blk_req <= 1'b1;
      tick(2);
      chk({29'h0, outs[2:0]}, 32'h0000_0001);
      apb(1'b0, lpf_pkg::A_STAT, 32'h0000_0000);
      chk(q, 32'h0000_0013);
      apb(1'b0, lpf_pkg::A_FSEL, 32'h0000_0000);
      chk(q, 32'h0000_0330);
      apb(1'b0, lpf_pkg::A_FW2, 32'h0000_0000);
      chk(q & 32'h0000_007F, 32'h0000_0032);
      apb(1'b0, lpf_pkg::A_FW1, 32'h0000_0000);
      chk(q & 32'h0FFF_FFFF, 32'h0A00_0002);
      blk_req <= 1'b0;
      pf_req <= 7'h64;
      tick(3);
      chk({27'h0, outs}, 32'h0000_0000);
      apb(1'b1, lpf_pkg::A_CTRL, 32'h0000_0001);
      pf_req <= 7'h55;
      tick(2);
      apb(1'b0, lpf_pkg::A_RATA, 32'h0000_0000);
      chk(q | {27'h0, outs}, 32'h0000_0000);
      apb(1'b1, lpf_pkg::A_CTRL, 32'h0000_0000);
      repeat (8)
      begin
         v = $unsigned($random(seed)) % 101;
         pf_req <= v[6:0];
         tick(1);
         apb(1'b0, lpf_pkg::A_RATA, 32'h0000_0000);
         chk(q, ratio(v, 90));
      end
      end_of_test();
   end
endmodule
